// *** rtl/mmr_agen_defines.svh ***
// Purpose: Constants for the data address generator used for register access.
// Assumes: Word addresses are 23 bits; data page 0 holds the registers.
// Notes: Included by the package and by the design module.
// What this block does
// - Compat bit 0: indexed coefficient operand posts temp_reg_0 onto pointer.
// - Compat bit 1: aux_pointer_0 replaces temp_reg_0 as post increment.
// - Coefficient double word: second address is first plus one if even, else minus one.
// - Dual multiply shares one fetched coefficient between both multipliers.
// - Registers live on page 0; short absolute reaches them when upper page is 0.
// - Short constant uses 2 extension bytes, long uses 3; no parallel pairing.
// - Long absolute is the address; short is upper page joined with constant.
// - Absolute double word reads first address, then first address plus one.
// - Direct operand reaches registers with the qualifier, whatever the compiler bit.
// - Register qualifier forces upper page, compiler bit and page pointer to zero.
// - Direct double word second address is base plus offset plus one.
// - Accumulator 0 low half at its address, upper half next, low first.
// - Indirect supports single, read-dual, write-dual and double word operands.
// - Indirect modes never read or write the interrupt enable register at zero.
// - Pointer mode 1 allows only the control-mode subset of indirect forms.
// - Coefficient pointer indirect allows plain, post inc/dec, offset, pre-added offset.
// - Extended pointers are 7-bit upper field joined with 16-bit lower pointer.
// - Post inc/dec steps by 1 for single word and 2 for double word.
`ifndef MMR_AGEN_DEFINES_SVH
`define MMR_AGEN_DEFINES_SVH
`define AG_ADDR_W        23
`define AG_HIGH_W        7
`define AG_LOW_W         16
`define AG_MMR_PAGE      7'h00
`define AG_LOCAL_BASE    16'h0000
`define AG_INTERRUPT_ENABLE_0_ADDR     23'h000000
`define AG_ACCUMULATOR0_LOW_ADDR     23'h000008
`define AG_AC0_MID_ADDR  23'h000009
`define AG_AR2_ADDR      23'h000012
`define AG_AR3_ADDR      23'h000013
`define AG_DOFFSET_MASK  16'h007F
`define AG_STEP_SINGLE   23'h000001
`define AG_STEP_DOUBLE   23'h000002
`define AG_EXT_NONE      2'h0
`define AG_EXT_SHORT     2'h2
`define AG_EXT_LONG      2'h3
`endif

// *** rtl/mmr_agen_pkg.sv ***
// Purpose: Types shared by the address generator and its bench.
// Assumes: Constants come from mmr_agen_defines.svh.
// Notes: Request and result travel as packed structs.
`include "mmr_agen_defines.svh"
package mmr_agen_pkg;
  typedef enum logic [2:0] {
    KIND_ABS16   = 3'h0,
    KIND_ABS23   = 3'h1,
    KIND_DIRECT  = 3'h2,
    KIND_IND_AR  = 3'h3,
    KIND_IND_CDP = 3'h4,
    KIND_CDP_IDX = 3'h5
  } addr_kind_t;

  typedef enum logic [3:0] {
    MOD_PLAIN      = 4'h0,
    MOD_POST_INC   = 4'h1,
    MOD_POST_DEC   = 4'h2,
    MOD_PRE_INC    = 4'h3,
    MOD_PRE_DEC    = 4'h4,
    MOD_IDX_ADD    = 4'h5,
    MOD_IDX_SUB    = 4'h6,
    MOD_IDX_OFF    = 4'h7,
    MOD_BITREV_ADD = 4'h8,
    MOD_BITREV_SUB = 4'h9,
    MOD_T1_ADD     = 4'hA,
    MOD_T1_SUB     = 4'hB,
    MOD_T1_OFF     = 4'hC,
    MOD_K16_OFF    = 4'hD,
    MOD_K16_PRE    = 4'hE,
    MOD_K3_OFF     = 4'hF
  } addr_mod_t;

  typedef enum logic [1:0] {
    BUS_SINGLE = 2'h0,
    BUS_DB_RD  = 2'h1,
    BUS_EB_WR  = 2'h2,
    BUS_DOUBLE = 2'h3
  } bus_kind_t;

  typedef struct packed {
    logic                   valid;
    addr_kind_t             kind;
    addr_mod_t              modifier;
    bus_kind_t              bus;
    logic                   mmap;
    logic                   dual_mul;
    logic [`AG_ADDR_W-1:0]  const_val;
  } agen_req_t;

  typedef struct packed {
    logic                   valid;
    logic                   double_word;
    bus_kind_t              bus;
    logic [`AG_ADDR_W-1:0]  addr;
    logic [`AG_ADDR_W-1:0]  addr2;
    logic                   coef_broadcast;
    logic                   no_parallel;
    logic [1:0]             ext_bytes;
  } agen_res_t;
endpackage : mmr_agen_pkg

// *** rtl/mmr_address_generation.sv ***
// Purpose: Data address generation for coefficient-pointer and register access.
// Assumes: One operand request per cycle; pointer values are current.
// Notes: All results are registered, one cycle after the request.
`timescale 1ns/1ns
`include "mmr_agen_defines.svh"

module mmr_address_generation
  import mmr_agen_pkg::*;
(
  input  wire logic                   i_clk,
  input  wire logic                   i_rstn,
  input  wire agen_req_t              i_req,
  input  wire logic                   i_compat_mode_bit,
  input  wire logic                   i_compiler_mode_bit,
  input  wire logic                   i_pointer_mode_bit,
  input  wire logic [`AG_HIGH_W-1:0]  i_upper_data_page,
  input  wire logic [`AG_LOW_W-1:0]   i_data_page_pointer,
  input  wire logic [`AG_LOW_W-1:0]   i_stack_pointer,
  input  wire logic [`AG_HIGH_W-1:0]  i_aux_pointer_high,
  input  wire logic [`AG_LOW_W-1:0]   i_aux_pointer_low,
  input  wire logic [`AG_HIGH_W-1:0]  i_coef_pointer_high,
  input  wire logic [`AG_LOW_W-1:0]   i_coef_pointer_low,
  input  wire logic [`AG_LOW_W-1:0]   i_temp_reg_0,
  input  wire logic [`AG_LOW_W-1:0]   i_temp_reg_1,
  input  wire logic [`AG_LOW_W-1:0]   i_aux_pointer_0,
  output agen_res_t                   o_res,
  output logic                        o_ptr_we,
  output logic                        o_ptr_is_coef,
  output logic [`AG_ADDR_W-1:0]       o_ptr_value,
  output logic                        o_illegal,
  output logic                        o_blocked
);

  localparam int AW = `AG_ADDR_W;

  // Index and offset words are signed and extended to 23 bits, so they move
  // a pointer within a signed 16-bit range in either direction.
  function automatic logic [AW-1:0] sext16(input logic [15:0] v);
    sext16 = {{(AW-16){v[15]}}, v};
  endfunction : sext16

  function automatic logic [15:0] rev16(input logic [15:0] v);
    logic [15:0] r;
    r = 16'h0000;
    for (int b = 0; b < 16; b++) begin
      r[b] = v[15-b];
    end
    rev16 = r;
  endfunction : rev16

  // Reverse-carry add on the low word; the upper field is left unchanged.
  function automatic logic [AW-1:0] bitrev_step(input logic [AW-1:0] p,
                                                input logic [15:0]   k,
                                                input logic          sub);
    logic [15:0] s;
    s = sub ? 16'(rev16(p[15:0]) - rev16(k))
            : 16'(rev16(p[15:0]) + rev16(k));
    bitrev_step = {p[AW-1:16], rev16(s)};
  endfunction : bitrev_step

  // Request decode.
  // Kinds become single wires so the later selections read plainly.
  wire logic is_ind_ar  = (i_req.kind == KIND_IND_AR);
  wire logic is_ind_cdp = (i_req.kind == KIND_IND_CDP);
  wire logic is_cdp_idx = (i_req.kind == KIND_CDP_IDX);
  wire logic is_direct  = (i_req.kind == KIND_DIRECT);
  wire logic is_abs16   = (i_req.kind == KIND_ABS16);
  wire logic is_abs23   = (i_req.kind == KIND_ABS23);
  wire logic is_coef    = is_ind_cdp | is_cdp_idx;
  wire logic is_ind     = is_ind_ar | is_coef;
  wire logic dbl        = (i_req.bus == BUS_DOUBLE);
  wire logic dual_bus   = (i_req.bus == BUS_DB_RD) |
                          (i_req.bus == BUS_EB_WR);

  // Extended pointers are the upper field joined to the lower word.
  wire logic [AW-1:0] aux_ext  = {i_aux_pointer_high,
                                  i_aux_pointer_low};
  wire logic [AW-1:0] coef_ext = {i_coef_pointer_high,
                                  i_coef_pointer_low};
  wire logic [AW-1:0] ptr      = is_coef ? coef_ext : aux_ext;

  // Steps follow the operand size so pointers stay on word pairs.
  wire logic [AW-1:0] step = dbl ? `AG_STEP_DOUBLE
                                 : `AG_STEP_SINGLE;
  // The compat bit swaps the index source for every T0/AR0 form.
  wire logic [AW-1:0] idx  = i_compat_mode_bit
                             ? sext16(i_aux_pointer_0)
                             : sext16(i_temp_reg_0);
  wire logic [AW-1:0] t1   = sext16(i_temp_reg_1);
  wire logic [AW-1:0] k16  = sext16(i_req.const_val[15:0]);
  wire logic [AW-1:0] k3   = {{(AW-3){1'b0}}, i_req.const_val[2:0]};
  wire logic [AW-1:0] zero = {AW{1'b0}};

  // Effective modifier: the indexed coefficient kind is a post add,
  // with its index chosen by the compat bit.
  wire addr_mod_t mod_eff = is_cdp_idx ? MOD_IDX_ADD : i_req.modifier;

  // Offset applied before the access; post forms add nothing here and
  // change only the pointer.
  logic [AW-1:0] ind_off;
  always_comb begin
    case (mod_eff)
      MOD_PRE_INC:  ind_off = step;
      MOD_PRE_DEC:  ind_off = AW'(zero - step);
      MOD_IDX_OFF:  ind_off = idx;
      MOD_T1_OFF:   ind_off = t1;
      MOD_K16_OFF,
      MOD_K16_PRE:  ind_off = k16;
      MOD_K3_OFF:   ind_off = k3;
      default:      ind_off = zero;
    endcase
  end

  wire logic [AW-1:0] ind_addr = AW'(ptr + ind_off);

  // Pointer update that the outside writes back; forms that leave the
  // pointer alone keep the write strobe low.
  logic [AW-1:0] ptr_next;
  logic          ptr_mod;
  always_comb begin
    ptr_mod  = 1'b1;
    ptr_next = ptr;
    case (mod_eff)
      MOD_POST_INC:   ptr_next = AW'(ptr + step);
      MOD_POST_DEC:   ptr_next = AW'(ptr - step);
      MOD_PRE_INC,
      MOD_PRE_DEC,
      MOD_K16_PRE:    ptr_next = ind_addr;
      MOD_IDX_ADD:    ptr_next = AW'(ptr + idx);
      MOD_IDX_SUB:    ptr_next = AW'(ptr - idx);
      MOD_BITREV_ADD: ptr_next = bitrev_step(ptr, idx[15:0], 1'b0);
      MOD_BITREV_SUB: ptr_next = bitrev_step(ptr, idx[15:0], 1'b1);
      MOD_T1_ADD:     ptr_next = AW'(ptr + t1);
      MOD_T1_SUB:     ptr_next = AW'(ptr - t1);
      default:        ptr_mod  = 1'b0;
    endcase
  end

  // Direct operand: the qualifier forces page, mode and base to zero.
  wire logic [15:0] doffset = i_req.const_val[15:0] &
                              `AG_DOFFSET_MASK;
  wire logic        dir_dp  = i_req.mmap |
                              ~i_compiler_mode_bit;
  wire logic [6:0]  dir_pg  = i_req.mmap ? `AG_MMR_PAGE
                                         : i_upper_data_page;
  wire logic [15:0] dir_bs  = i_req.mmap ? `AG_LOCAL_BASE
                              : (dir_dp ? i_data_page_pointer
                                        : i_stack_pointer);
  wire logic [AW-1:0] dir_addr = {dir_pg, 16'(dir_bs + doffset)};

  // Short absolute joins the upper page; long absolute is used as is.
  // A nonzero upper page takes the short form off page 0, so registers
  // are then out of reach; the program must clear the page first.
  wire logic [AW-1:0] abs16_addr = {i_upper_data_page,
                                    i_req.const_val[15:0]};
  wire logic [AW-1:0] abs23_addr = i_req.const_val;

  // First-word address, chosen by the operand kind.
  logic [AW-1:0] addr1;
  always_comb begin
    case (i_req.kind)
      KIND_ABS16:   addr1 = abs16_addr;
      KIND_ABS23:   addr1 = abs23_addr;
      KIND_DIRECT:  addr1 = dir_addr;
      KIND_IND_AR,
      KIND_IND_CDP,
      KIND_CDP_IDX: addr1 = ind_addr;
      default:      addr1 = zero;
    endcase
  end

  // Indirect pairs stay inside an aligned pair; absolute and direct
  // simply step up, which keeps the low half of a register first.
  wire logic [AW-1:0] addr2_ind = addr1[0] ? AW'(addr1 - 1'b1)
                                           : AW'(addr1 + 1'b1);
  wire logic [AW-1:0] addr2_lin = AW'(addr1 + 1'b1);
  wire logic [AW-1:0] addr2 = is_ind ? addr2_ind : addr2_lin;

  // Pointer mode 1 admits only the control-mode subset.
  wire logic dsp_only = (mod_eff == MOD_PRE_INC) |
                        (mod_eff == MOD_PRE_DEC) |
                        (mod_eff == MOD_BITREV_ADD) |
                        (mod_eff == MOD_BITREV_SUB) |
                        (mod_eff == MOD_T1_ADD) |
                        (mod_eff == MOD_T1_SUB) |
                        (mod_eff == MOD_T1_OFF);
  wire logic ar_bad   = is_ind_ar &
                        ((i_pointer_mode_bit & dsp_only) |
                         (~i_pointer_mode_bit &
                          (mod_eff == MOD_K3_OFF)));
  wire logic cdp_ok   = (mod_eff == MOD_PLAIN) |
                        (mod_eff == MOD_POST_INC) |
                        (mod_eff == MOD_POST_DEC) |
                        (mod_eff == MOD_K16_OFF) |
                        (mod_eff == MOD_K16_PRE);
  wire logic cdp_bad  = is_ind_cdp & ~cdp_ok;
  // Read-dual and write-dual operands exist only in indirect form.
  wire logic bus_bad  = dual_bus & ~is_ind;
  wire logic illegal  = i_req.valid & (ar_bad | cdp_bad | bus_bad);

  // The interrupt enable register is unreachable through any pointer.
  // The second word is checked too, so a double access starting at
  // address one cannot reach the register from above.
  wire logic hit_interrupt_enable_0 = (addr1 == `AG_INTERRUPT_ENABLE_0_ADDR) |
                        (dbl & (addr2 == `AG_INTERRUPT_ENABLE_0_ADDR));
  wire logic blocked  = i_req.valid & ~illegal &
                        is_ind & hit_interrupt_enable_0;
  wire logic accept   = i_req.valid & ~illegal & ~blocked;

  // Constant extensions bar pairing with another instruction.
  wire logic k16_mod  = is_ind & ((mod_eff == MOD_K16_OFF) |
                                  (mod_eff == MOD_K16_PRE));
  wire logic [1:0] ext_bytes = is_abs23 ? `AG_EXT_LONG
                             : (is_abs16 | k16_mod) ? `AG_EXT_SHORT
                             : `AG_EXT_NONE;

  // The result word gathers all that the register decoder needs; it is
  // cleared first so that unused fields never carry stale bits.
  agen_res_t res_d;
  always_comb begin
    res_d                = '0;
    res_d.valid          = accept;
    res_d.double_word    = dbl;
    res_d.bus            = i_req.bus;
    res_d.addr           = addr1;
    res_d.addr2          = dbl ? addr2 : addr1;
    // One coefficient feeds both multipliers of a dual multiply.
    res_d.coef_broadcast = accept & i_req.dual_mul & is_coef;
    res_d.no_parallel    = accept & (ext_bytes != `AG_EXT_NONE);
    res_d.ext_bytes      = ext_bytes;
  end

  // A refused operand leaves its pointer untouched.
  wire logic ptr_we_d = accept & is_ind & ptr_mod;

  agen_res_t     res_q;
  logic          ptr_we_q;
  logic          ptr_coef_q;
  logic [AW-1:0] ptr_val_q;
  logic          illegal_q;
  logic          blocked_q;

  // Each output has its own short register. All reload every cycle, so
  // a refusal or a pointer write stands for one cycle only.
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      res_q <= '0;
    end else begin
      res_q <= res_d;
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      ptr_we_q <= 1'b0;
    end else begin
      ptr_we_q <= ptr_we_d;
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      ptr_coef_q <= 1'b0;
    end else begin
      ptr_coef_q <= is_coef;
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      ptr_val_q <= '0;
    end else begin
      ptr_val_q <= ptr_next;
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      illegal_q <= 1'b0;
    end else begin
      illegal_q <= illegal;
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      blocked_q <= 1'b0;
    end else begin
      blocked_q <= blocked;
    end
  end

  // Outputs come straight from the registers, with no logic behind them.
  assign o_res         = res_q;
  assign o_ptr_we      = ptr_we_q;
  assign o_ptr_is_coef = ptr_coef_q;
  assign o_ptr_value   = ptr_val_q;
  assign o_illegal     = illegal_q;
  assign o_blocked     = blocked_q;

endmodule : mmr_address_generation

// *** test/mmr_agen_chk.sv ***
// Purpose: Port-level checks for the register address generator.
// Assumes: Every request is answered on the next edge.
// Notes: Bound to the design below the module.
`timescale 1ns/1ns
`include "mmr_agen_defines.svh"
module mmr_agen_chk
  import mmr_agen_pkg::*;
(
  input wire logic                  i_clk,
  input wire logic                  i_rstn,
  input wire agen_req_t             i_req,
  input wire logic                  i_compat_mode_bit,
  input wire logic                  i_pointer_mode_bit,
  input wire logic [`AG_HIGH_W-1:0] i_upper_data_page,
  input wire logic [`AG_HIGH_W-1:0] i_aux_pointer_high,
  input wire logic [`AG_LOW_W-1:0]  i_aux_pointer_low,
  input wire logic [`AG_HIGH_W-1:0] i_coef_pointer_high,
  input wire logic [`AG_LOW_W-1:0]  i_coef_pointer_low,
  input wire logic [`AG_LOW_W-1:0]  i_temp_reg_0,
  input wire logic [`AG_LOW_W-1:0]  i_aux_pointer_0,
  input wire agen_res_t             o_res,
  input wire logic                  o_ptr_we,
  input wire logic [`AG_ADDR_W-1:0] o_ptr_value,
  input wire logic                  o_illegal,
  input wire logic                  o_blocked
);
  agen_req_t   req_q;
  logic [6:0]  page_q;
  logic [22:0] cptr_q;
  logic [15:0] idx_q;
  // Single and double are the only bus kinds legal outside indirect forms.
  wire logic   plain_bus = i_req.bus[0] == i_req.bus[1];
  wire logic   go = i_req.valid;
  always_ff @(posedge i_clk) begin
    req_q  <= i_req;
    page_q <= i_upper_data_page;
    cptr_q <= {i_coef_pointer_high, i_coef_pointer_low};
    idx_q  <= i_compat_mode_bit ? i_aux_pointer_0 : i_temp_reg_0;
  end
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rstn);
  chk_one_answer: assert property (
    go |=> o_res.valid | o_illegal | o_blocked)
    else $error("request got no answer");
  chk_long_abs: assert property (
    go && i_req.kind == KIND_ABS23 && plain_bus |=> o_res.valid
    && o_res.addr == req_q.const_val && o_res.ext_bytes == 2'h3)
    else $error("long absolute address wrong");
  chk_short_abs: assert property (
    go && i_req.kind == KIND_ABS16 && plain_bus |=> o_res.ext_bytes == 2'h2
    && o_res.addr == {page_q, req_q.const_val[15:0]} && o_res.no_parallel)
    else $error("short absolute address wrong");
  chk_pair_next: assert property (
    go && i_req.kind inside {KIND_ABS16, KIND_ABS23, KIND_DIRECT}
    && i_req.bus == BUS_DOUBLE |=> o_res.double_word
    && o_res.addr2 == o_res.addr + 23'h000001)
    else $error("second word address wrong");
  chk_mmap_base: assert property (
    go && i_req.kind == KIND_DIRECT && i_req.mmap && plain_bus
    |=> o_res.addr == {16'h0000, req_q.const_val[6:0]})
    else $error("qualified direct address wrong");
  chk_interrupt_enable_0_guard: assert property (
    go && i_req.kind == KIND_IND_AR && i_req.modifier == MOD_PLAIN
    && i_req.bus == BUS_SINGLE
    && {i_aux_pointer_high, i_aux_pointer_low} == 23'h000000
    |=> o_blocked && !o_res.valid && !o_ptr_we)
    else $error("indirect access to address zero not blocked");
  chk_coef_step: assert property (
    go && i_req.kind == KIND_CDP_IDX && i_req.bus == BUS_SINGLE
    && {i_coef_pointer_high, i_coef_pointer_low} != 23'h000000
    |=> o_ptr_we && o_ptr_value == cptr_q + {{7{idx_q[15]}}, idx_q})
    else $error("coefficient pointer step wrong");
  chk_ctrl_subset: assert property (
    go && i_pointer_mode_bit && i_req.kind == KIND_IND_AR
    && i_req.modifier inside {MOD_PRE_INC, MOD_PRE_DEC, MOD_BITREV_ADD,
    MOD_BITREV_SUB, MOD_T1_ADD, MOD_T1_SUB, MOD_T1_OFF}
    |=> o_illegal && !o_res.valid && !o_ptr_we)
    else $error("control mode form not refused");
endmodule : mmr_agen_chk
bind mmr_address_generation mmr_agen_chk i_mmr_agen_chk (.i_clk, .i_rstn,
  .i_req, .i_compat_mode_bit, .i_pointer_mode_bit, .i_upper_data_page,
  .i_aux_pointer_high, .i_aux_pointer_low, .i_coef_pointer_high,
  .i_coef_pointer_low, .i_temp_reg_0, .i_aux_pointer_0, .o_res, .o_ptr_we,
  .o_ptr_value, .o_illegal, .o_blocked);

// *** test/mmr_space_model.sv ***
// Purpose: Register space on data page 0 that answers generated addresses.
// Assumes: Each word holds 16'hC000 plus its offset.
// Notes: Above word 127 of page 0, off page 0 or without a valid result it shows inverted data.
`timescale 1ns/1ns
module mmr_space_model
  import mmr_agen_pkg::*;
(
  input  wire agen_res_t i_res,
  output logic [15:0]    o_word0,
  output logic [15:0]    o_word1
);
  logic [15:0] mem [0:127];
  wire logic   on0 = i_res.valid && i_res.addr[22:7] == 16'h0000;
  wire logic   on1 = i_res.valid && i_res.addr2[22:7] == 16'h0000;
  initial begin
    // Accumulator 0 low half sits at 8 and its upper half at 9.
    for (int i = 0; i < 128; i++) mem[i] = 16'hC000 + 16'(i);
  end
  assign o_word0 = on0 ? mem[i_res.addr[6:0]] : ~mem[i_res.addr[6:0]];
  assign o_word1 = on1 ? mem[i_res.addr2[6:0]] : ~mem[i_res.addr2[6:0]];
endmodule : mmr_space_model

// *** test/tb.sv ***
// Purpose: Directed scenarios for the register address generator.
// Assumes: Inputs change at the falling edge; answers one cycle later.
// Notes: Pointer inputs are reloaded by the bench between requests.
`timescale 1ns/1ns
module tb;
  import mmr_agen_pkg::*;
  logic        i_clk = 1'b0, i_rstn = 1'b0, dual = 1'b0;
  logic        i_compat_mode_bit = 1'b0, i_compiler_mode_bit = 1'b0;
  logic        i_pointer_mode_bit = 1'b0;
  agen_req_t   i_req = '0;
  logic [6:0]  i_upper_data_page = '0, i_aux_pointer_high = '0;
  logic [6:0]  i_coef_pointer_high = '0;
  logic [15:0] i_data_page_pointer = '0, i_stack_pointer = 16'h0100;
  logic [15:0] i_aux_pointer_low = '0, i_coef_pointer_low = '0;
  logic [15:0] i_temp_reg_0 = '0, i_temp_reg_1 = 16'h0004;
  logic [15:0] i_aux_pointer_0 = '0, word0, word1;
  agen_res_t   o_res;
  logic        o_ptr_we, o_ptr_is_coef, o_illegal, o_blocked;
  logic [22:0] o_ptr_value;
  int          miscompares = 0, total_checks = 0, cycles = 0;
  mmr_address_generation i_mmr_address_generation (.i_clk, .i_rstn, .i_req,
    .i_compat_mode_bit, .i_compiler_mode_bit, .i_pointer_mode_bit,
    .i_upper_data_page, .i_data_page_pointer, .i_stack_pointer,
    .i_aux_pointer_high, .i_aux_pointer_low, .i_coef_pointer_high,
    .i_coef_pointer_low, .i_temp_reg_0, .i_temp_reg_1, .i_aux_pointer_0,
    .o_res, .o_ptr_we, .o_ptr_is_coef, .o_ptr_value, .o_illegal, .o_blocked);
  mmr_space_model i_mmr_space_model (.i_res(o_res), .o_word0(word0),
    .o_word1(word1));
  always #2 i_clk = ~i_clk;
  always @(posedge i_clk) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      miscompares++;
      stop_test();
    end
  end
  task automatic stop_test();
    $display("Checks %0d, mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : stop_test
  task automatic check(input logic [47:0] seen, input logic [47:0] exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  // Called at a falling edge; returns when the answer has settled.
  task automatic op(input addr_kind_t k, input addr_mod_t m,
                    input bus_kind_t b, input logic [22:0] c);
    i_req = '{1'b1, k, m, b, 1'b1, dual, c};
    @(negedge i_clk);
  endtask : op
  task automatic t_absolute();
    op(KIND_ABS23, MOD_PLAIN, BUS_DOUBLE, 23'h000008);
    check({o_res.valid, o_res.addr, o_res.ext_bytes}, {1'b1, 23'h8, 2'h3});
    check({o_res.addr2, o_res.no_parallel}, {23'h000009, 1'b1});
    check({word0, word1}, 32'hC008C009);
    op(KIND_ABS16, MOD_PLAIN, BUS_DOUBLE, 23'h000012);
    check({o_res.addr, o_res.addr2}, {23'h000012, 23'h000013});
    check({o_res.ext_bytes, o_res.no_parallel}, {2'h2, 1'b1});
    i_upper_data_page = 7'h05;
    op(KIND_ABS16, MOD_PLAIN, BUS_SINGLE, 23'h000012);
    check({o_res.addr, o_res.double_word}, {23'h050012, 1'b0});
  endtask : t_absolute
  task automatic t_direct();
    i_data_page_pointer = 16'h4000;
    i_compiler_mode_bit = 1'b1;
    op(KIND_DIRECT, MOD_PLAIN, BUS_DOUBLE, 23'h001234);
    check({o_res.addr, o_res.addr2}, {23'h000034, 23'h000035});
    check({word0, word1}, 32'hC034C035);
    i_req.mmap = 1'b0;
    @(negedge i_clk);
    check({o_res.addr, word0}, {23'h050134, 16'h3FCB});
    i_compiler_mode_bit = 1'b0;
    @(negedge i_clk);
    check(o_res.addr, 23'h054034);
  endtask : t_direct
  task automatic t_coef();
    {i_coef_pointer_high, i_coef_pointer_low} = 23'h000010;
    i_temp_reg_0 = 16'h0003;
    i_aux_pointer_0 = 16'h0007;
    dual = 1'b1;
    op(KIND_CDP_IDX, MOD_IDX_ADD, BUS_SINGLE, 23'h0);
    check({o_res.addr, o_ptr_we, o_ptr_is_coef, o_ptr_value},
          {23'h10, 2'b11, 23'h13});
    check({o_res.valid, o_res.coef_broadcast}, 2'b11);
    i_compat_mode_bit = 1'b1;
    op(KIND_CDP_IDX, MOD_IDX_ADD, BUS_SINGLE, 23'h0);
    check(o_ptr_value, 23'h000017);
    i_compat_mode_bit = 1'b0;
    i_temp_reg_0 = 16'hFFFE;
    {i_coef_pointer_high, i_coef_pointer_low} = 23'h000011;
    op(KIND_CDP_IDX, MOD_IDX_ADD, BUS_DOUBLE, 23'h0);
    check({o_res.addr, o_res.addr2}, {23'h000011, 23'h000010});
    check(o_ptr_value, 23'h00000F);
    dual = 1'b0;
    op(KIND_IND_CDP, MOD_K16_PRE, BUS_SINGLE, 23'h000008);
    check({o_res.addr, o_ptr_is_coef, o_ptr_value, o_res.coef_broadcast},
          {23'h19, 1'b1, 23'h19, 1'b0});
  endtask : t_coef
  task automatic t_indirect();
    i_pointer_mode_bit = 1'b1;
    {i_aux_pointer_high, i_aux_pointer_low} = 23'h000012;
    op(KIND_IND_AR, MOD_POST_INC, BUS_DOUBLE, 23'h0);
    check({o_res.addr, o_res.addr2}, {23'h000012, 23'h000013});
    check({o_ptr_we, o_ptr_is_coef, o_ptr_value}, {2'b10, 23'h14});
    {i_aux_pointer_high, i_aux_pointer_low} = 23'h010009;
    for (int b = 0; b < 4; b++) begin
      op(KIND_IND_AR, MOD_PLAIN, bus_kind_t'(b), 23'h0);
      check({o_res.valid, o_res.bus, o_res.addr}, {1'b1, 2'(b), 23'h010009});
      check(o_res.addr2, b == 3 ? 23'h010008 : 23'h010009);
    end
    op(KIND_IND_AR, MOD_POST_DEC, BUS_SINGLE, 23'h0);
    check({o_ptr_we, o_ptr_value}, {1'b1, 23'h010008});
  endtask : t_indirect
  task automatic t_refuse();
    addr_mod_t bad[7] = '{MOD_PRE_INC, MOD_PRE_DEC, MOD_BITREV_ADD,
                          MOD_BITREV_SUB, MOD_T1_ADD, MOD_T1_SUB, MOD_T1_OFF};
    {i_aux_pointer_high, i_aux_pointer_low} = 23'h000000;
    op(KIND_IND_AR, MOD_PLAIN, BUS_SINGLE, 23'h0);
    check({o_blocked, o_res.valid, o_ptr_we}, 3'b100);
    {i_aux_pointer_high, i_aux_pointer_low} = 23'h000001;
    op(KIND_IND_AR, MOD_POST_INC, BUS_DOUBLE, 23'h0);
    check({o_blocked, o_res.valid, o_ptr_we}, 3'b100);
    {i_aux_pointer_high, i_aux_pointer_low} = 23'h000012;
    foreach (bad[i]) begin
      op(KIND_IND_AR, bad[i], BUS_SINGLE, 23'h0);
      check({o_illegal, o_res.valid, o_ptr_we}, 3'b100);
    end
    i_pointer_mode_bit = 1'b0;
    op(KIND_IND_AR, MOD_K3_OFF, BUS_SINGLE, 23'h000002);
    check({o_illegal, o_res.valid}, 2'b10);
    op(KIND_IND_CDP, MOD_PRE_INC, BUS_SINGLE, 23'h0);
    check({o_illegal, o_ptr_we}, 2'b10);
    op(KIND_ABS23, MOD_PLAIN, BUS_DB_RD, 23'h000008);
    check({o_illegal, o_res.valid}, 2'b10);
  endtask : t_refuse
  initial begin
    repeat (3) @(negedge i_clk);
    i_rstn = 1'b1;
    t_absolute();
    t_direct();
    t_coef();
    t_indirect();
    t_refuse();
    stop_test();
  end
endmodule : tb
